// ==== design/sadio_cfg.svh ====
// constants for the status, alarm and remote control block
`ifndef SADIO_CFG_SVH
`define SADIO_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SADIO_OFS_CTRL       12'h000
`define SADIO_OFS_LIMIT1     12'h004
`define SADIO_OFS_LIMIT2     12'h008
`define SADIO_OFS_CONC       12'h00C
`define SADIO_OFS_INST       12'h010
`define SADIO_OFS_STATUS_OUT 12'h014
`define SADIO_OFS_IRQ_STAT   12'h018
`define SADIO_OFS_IRQ_MASK   12'h01C
`define SADIO_OFS_UNIT_SCALE 12'h020

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define SADIO_CTRL_EN1      0
`define SADIO_CTRL_EN2      1
`define SADIO_CTRL_UNIT     2
`define SADIO_CTRL_RANGEMD0 4
`define SADIO_CTRL_RANGEMD1 5

// ----------------------------------------------------------------------
// instrument state fields
// ----------------------------------------------------------------------
`define SADIO_INST_FAULT   0
`define SADIO_INST_VALID   1
`define SADIO_INST_HIRANGE 2
`define SADIO_INST_ZERO    3
`define SADIO_INST_SPAN    4
`define SADIO_INST_DIAG    5

// ----------------------------------------------------------------------
// reset values; limits held in ppm units at reset
// ----------------------------------------------------------------------
`define SADIO_LIMIT1_RST 32'h0000_0064
`define SADIO_LIMIT2_RST 32'h0000_012C
`define SADIO_SCALE_RST  32'h0000_0002

// ----------------------------------------------------------------------
// debounce time: 1 ms at 5 ns period
// ----------------------------------------------------------------------
`define SADIO_DEB_US     1000
`define SADIO_CLK_NS     5
`define SADIO_DEB_CYC    ((`SADIO_DEB_US * 1000) / `SADIO_CLK_NS)

// range mode codes
`define SADIO_RMODE_SINGLE 2'h0
`define SADIO_RMODE_DUAL   2'h1
`define SADIO_RMODE_AUTO   2'h2

`endif

// ==== design/sadio_pkg.sv ====
// types for the status, alarm and remote control block
package sadio_pkg;

   // the eight discrete status outputs
   typedef struct packed {
      logic second_limit_flag;
      logic first_limit_flag;
      logic diagnostic_active_flag;
      logic span_cal;
      logic zero_cal;
      logic high_range;
      logic measurement_good_flag;
      logic no_fault;
   } sadio_status_s;

   // remote calibration mode indication
   typedef enum logic [1:0] {
      SADIO_REM_NONE,
      SADIO_REM_ZERO,
      SADIO_REM_SPAN
   } sadio_rem_e;

   // apb slave request
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } sadio_apb_req_s;

endpackage

// ==== design/sadio_top.sv ====
// status outputs, concentration alarms and remote calibration inputs
`timescale 1ns/10ps
`include "sadio_cfg.svh"

module sadio_top #(
   parameter int unsigned DEB_CYC = `SADIO_DEB_CYC
) (
   // clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   // apb slave
   input  wire sadio_pkg::sadio_apb_req_s apb_req,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   // remote control inputs
   input  wire logic                   rem_zero_in,
   input  wire logic                   rem_span_in,
   input  wire logic [3:0]             spare_in,
   // status outputs and indications
   output sadio_pkg::sadio_status_s    status_out,
   output sadio_pkg::sadio_rem_e       rem_mode,
   output logic                        irq
);
   import sadio_pkg::*;

   // ----------------------------------------------------------------------
   // local state
   // ----------------------------------------------------------------------
   logic [31:0]   limit1_q;
   logic [31:0]   limit2_q;
   logic [31:0]   conc_q;
   logic [31:0]   scale_q;
   logic          en1_q;
   logic          en2_q;
   logic          unit_q;
   logic [1:0]    rmode_q;
   logic [5:0]    inst_q;
   logic [7:0]    irq_stat_q;
   logic [7:0]    irq_mask_q;
   logic [1:0]    zero_sync_q;
   logic [1:0]    span_sync_q;
   logic          zero_deb_q;
   logic          span_deb_q;
   logic [19:0]   zero_cnt_q;
   logic [19:0]   span_cnt_q;
   sadio_rem_e    rem_q;
   sadio_status_s stat_d;
   sadio_status_s stat_q;
   logic          wr_en;
   logic          rd_en;
   logic          unit_new;
   logic [31:0]   rdata_d;
   logic          addr_ok;
   logic [31:0]   rdata_q;
   logic          irq_q;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------

   // convert limit when unit flips: 1 = to scaled, 0 = back
   function automatic logic [31:0] rescale(input logic [31:0] v,
                                           input logic [31:0] s,
                                           input logic        up);
      logic [63:0] p;
      p = 64'(v) * 64'(s);
      if (up)
         rescale = p[31:0];
      else if (s == 32'h0000_0000)
         rescale = v;
      else
         rescale = v / s;
   endfunction

   // alarm comparison gated by its enable
   function automatic logic over_limit(input logic        en,
                                       input logic [31:0] c,
                                       input logic [31:0] l);
      over_limit = en && (c > l);
   endfunction

   // ----------------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------------
   assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
   // read setup phase: data is captured here for the access phase
   assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
   assign pready = 1'b1;
   assign unit_new = apb_req.pwdata[`SADIO_CTRL_UNIT];

   // unmapped address check
   always_comb begin
      case (apb_req.paddr)
         `SADIO_OFS_CTRL, `SADIO_OFS_LIMIT1, `SADIO_OFS_LIMIT2,
         `SADIO_OFS_CONC, `SADIO_OFS_INST, `SADIO_OFS_STATUS_OUT,
         `SADIO_OFS_IRQ_STAT, `SADIO_OFS_IRQ_MASK,
         `SADIO_OFS_UNIT_SCALE: addr_ok = 1'b1;
         default:               addr_ok = 1'b0;
      endcase
   end

   assign pslverr = apb_req.psel && apb_req.penable && !addr_ok;

   // ----------------------------------------------------------------------
   // control register and alarm limits
   // ----------------------------------------------------------------------

   always_ff @(posedge core_clk) begin
      if (rst) begin
         en1_q    <= 1'b0;
         en2_q    <= 1'b0;
         unit_q   <= 1'b0;
         rmode_q  <= `SADIO_RMODE_SINGLE;
         limit1_q <= `SADIO_LIMIT1_RST;
         limit2_q <= `SADIO_LIMIT2_RST;
         scale_q  <= `SADIO_SCALE_RST;
      end else if (wr_en) begin
         case (apb_req.paddr)
            `SADIO_OFS_CTRL: begin
               en1_q   <= apb_req.pwdata[`SADIO_CTRL_EN1];
               en2_q   <= apb_req.pwdata[`SADIO_CTRL_EN2];
               rmode_q <= apb_req.pwdata[`SADIO_CTRL_RANGEMD1:
                                         `SADIO_CTRL_RANGEMD0];
               unit_q  <= unit_new;
               if (unit_new != unit_q) begin
                  limit1_q <= rescale(limit1_q, scale_q, unit_new);
                  limit2_q <= rescale(limit2_q, scale_q, unit_new);
               end
            end
            `SADIO_OFS_LIMIT1:     limit1_q <= apb_req.pwdata;
            `SADIO_OFS_LIMIT2:     limit2_q <= apb_req.pwdata;
            `SADIO_OFS_UNIT_SCALE: scale_q  <= apb_req.pwdata;
            default: ;
         endcase
      end
   end

   // measured concentration and instrument state written by firmware
   always_ff @(posedge core_clk) begin
      if (rst) begin
         conc_q <= 32'h0000_0000;
         inst_q <= 6'h00;
      end else if (wr_en && apb_req.paddr == `SADIO_OFS_CONC) begin
         conc_q <= apb_req.pwdata;
      end else if (wr_en && apb_req.paddr == `SADIO_OFS_INST) begin
         inst_q <= apb_req.pwdata[5:0];
      end
   end

   // ----------------------------------------------------------------------
   // remote inputs: synchroniser and debounce
   // ----------------------------------------------------------------------

   always_ff @(posedge core_clk) begin
      if (rst) begin
         zero_sync_q <= 2'h0;
         span_sync_q <= 2'h0;
      end else begin
         zero_sync_q <= {zero_sync_q[0], rem_zero_in};
         span_sync_q <= {span_sync_q[0], rem_span_in};
      end
   end

   // debounce: level must hold for the full window
   always_ff @(posedge core_clk) begin
      if (rst) begin
         zero_cnt_q <= 20'h00000;
         zero_deb_q <= 1'b0;
      end else if (zero_sync_q[1] == zero_deb_q) begin
         zero_cnt_q <= 20'h00000;
      end else if (zero_cnt_q == 20'(DEB_CYC - 1)) begin
         zero_cnt_q <= 20'h00000;
         zero_deb_q <= zero_sync_q[1];
      end else begin
         zero_cnt_q <= zero_cnt_q + 20'h00001;
      end
   end

   // span input debounce, same window as zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         span_cnt_q <= 20'h00000;
         span_deb_q <= 1'b0;
      end else if (span_sync_q[1] == span_deb_q) begin
         span_cnt_q <= 20'h00000;
      end else if (span_cnt_q == 20'(DEB_CYC - 1)) begin
         span_cnt_q <= 20'h00000;
         span_deb_q <= span_sync_q[1];
      end else begin
         span_cnt_q <= span_cnt_q + 20'h00001;
      end
   end

   // ----------------------------------------------------------------------
   // remote calibration mode
   // ----------------------------------------------------------------------

   // spare inputs never reach this logic
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rem_q <= SADIO_REM_NONE;
      end else begin
         case (rem_q)
            SADIO_REM_NONE: begin
               if (zero_deb_q)
                  rem_q <= SADIO_REM_ZERO;
               else if (span_deb_q)
                  rem_q <= SADIO_REM_SPAN;
            end
            SADIO_REM_ZERO: begin
               if (!zero_deb_q)
                  rem_q <= SADIO_REM_NONE;
            end
            SADIO_REM_SPAN: begin
               if (!span_deb_q)
                  rem_q <= SADIO_REM_NONE;
            end
            default: rem_q <= SADIO_REM_NONE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // status outputs
   // ----------------------------------------------------------------------
   // next value of the eight status outputs
   always_comb begin
      stat_d.no_fault = !inst_q[`SADIO_INST_FAULT];
      stat_d.measurement_good_flag = inst_q[`SADIO_INST_VALID];
      // upper-scale only in dual or auto
      stat_d.high_range = inst_q[`SADIO_INST_HIRANGE] &&
                          (rmode_q == `SADIO_RMODE_DUAL ||
                           rmode_q == `SADIO_RMODE_AUTO);
      stat_d.zero_cal = inst_q[`SADIO_INST_ZERO] ||
                        rem_q == SADIO_REM_ZERO;
      stat_d.span_cal = inst_q[`SADIO_INST_SPAN] ||
                        rem_q == SADIO_REM_SPAN;
      stat_d.diagnostic_active_flag = inst_q[`SADIO_INST_DIAG];
      // alarm comparisons, disabled alarm held off
      stat_d.first_limit_flag  = over_limit(en1_q, conc_q, limit1_q);
      stat_d.second_limit_flag = over_limit(en2_q, conc_q, limit2_q);
   end

   // status outputs from flip-flops, all off during reset
   always_ff @(posedge core_clk) begin
      if (rst)
         stat_q <= '0;
      else
         stat_q <= stat_d;
   end

   assign status_out = stat_q;
   assign rem_mode   = rem_q;

   // ----------------------------------------------------------------------
   // interrupts: rising edge of any status bit sets a sticky bit
   // ----------------------------------------------------------------------
   // sticky event bits, write one to clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_stat_q <= 8'h00;
      end else begin
         // set wins over write-one-to-clear
         irq_stat_q <= (irq_stat_q &
                        ~((wr_en &&
                           apb_req.paddr == `SADIO_OFS_IRQ_STAT) ?
                          apb_req.pwdata[7:0] : 8'h00)) |
                       (stat_d & ~stat_q);
      end
   end

   // interrupt mask, same layout as the sticky bits
   always_ff @(posedge core_clk) begin
      if (rst)
         irq_mask_q <= 8'h00;
      else if (wr_en && apb_req.paddr == `SADIO_OFS_IRQ_MASK)
         irq_mask_q <= apb_req.pwdata[7:0];
   end

   // level interrupt from a flip-flop, one cycle behind the bits
   always_ff @(posedge core_clk) begin
      if (rst)
         irq_q <= 1'b0;
      else
         irq_q <= |(irq_stat_q & irq_mask_q);
   end

   assign irq = irq_q;

   // ----------------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------------
   // register read selection
   always_comb begin
      case (apb_req.paddr)
         `SADIO_OFS_CTRL:
            rdata_d = {26'h0, rmode_q, 1'b0, unit_q, en2_q, en1_q};
         `SADIO_OFS_LIMIT1:     rdata_d = limit1_q;
         `SADIO_OFS_LIMIT2:     rdata_d = limit2_q;
         `SADIO_OFS_CONC:       rdata_d = conc_q;
         `SADIO_OFS_INST:       rdata_d = {26'h0, inst_q};
         `SADIO_OFS_STATUS_OUT: rdata_d = {22'h0, rem_q, stat_q};
         `SADIO_OFS_IRQ_STAT:   rdata_d = {24'h0, irq_stat_q};
         `SADIO_OFS_IRQ_MASK:   rdata_d = {24'h0, irq_mask_q};
         `SADIO_OFS_UNIT_SCALE: rdata_d = scale_q;
         default:               rdata_d = 32'h0000_0000;
      endcase
   end

   // read data taken in setup, so it stands through the access phase
   // and is zero in every other cycle
   always_ff @(posedge core_clk) begin
      if (rst || !rd_en)
         rdata_q <= 32'h0000_0000;
      else
         rdata_q <= rdata_d;
   end

   assign prdata = rdata_q;

endmodule

// ==== tb/sadio_plc_model.sv ====
// controller model driving the remote and spare control inputs
`timescale 1ns/10ps
module sadio_plc_model (
   // clock
   input wire logic    core_clk,
   // control inputs toward the block
   output logic        rem_zero_in,
   output logic        rem_span_in,
   output logic [3:0]  spare_in
);
   // idle levels
   initial begin
      rem_zero_in = 1'b0;
      rem_span_in = 1'b0;
      spare_in    = 4'h0;
   end

   // hold requested levels for n cycles
   task automatic drive(input logic z, input logic s,
                        input logic [3:0] sp, input int n);
      begin
         @(posedge core_clk);
         rem_zero_in <= z;
         rem_span_in <= s;
         spare_in    <= sp;
         repeat (n) @(posedge core_clk);
      end
   endtask
endmodule

// ==== tb/sadio_top_asserts.sv ====
// port checker for the status, alarm and remote control block
`timescale 1ns/10ps
module sadio_top_asserts #(
   parameter int unsigned DEB_CYC = 4
) (
   // clock and reset
   input wire logic                      core_clk,
   input wire logic                      rst,
   // apb
   input wire sadio_pkg::sadio_apb_req_s apb_req,
   input wire logic [31:0]               prdata,
   input wire logic                      pready,
   input wire logic                      pslverr,
   // remote inputs
   input wire logic                      rem_zero_in,
   input wire logic                      rem_span_in,
   input wire logic [3:0]                spare_in,
   // outputs
   input wire sadio_pkg::sadio_status_s  status_out,
   input wire sadio_pkg::sadio_rem_e     rem_mode,
   input wire logic                      irq
);
   import sadio_pkg::*;
   logic wr_acc;

   // write access phase
   assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;

   default clocking dcb @(posedge core_clk); endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   AST_READY: assert property (apb_req.psel |-> pready)
      else $error("pready low in transfer");
   AST_ERR_IDLE: assert property (!apb_req.psel |-> !pslverr)
      else $error("pslverr outside transfer");
   AST_RD_IDLE: assert property (!apb_req.psel |-> prdata == 32'h0)
      else $error("prdata not zero when idle");
   AST_RST_VALS: assert property ($past(rst) |->
      status_out == 8'h00 && rem_mode == SADIO_REM_NONE && !irq)
      else $error("outputs not cleared by reset");
   AST_REM_ZERO: assert property (
      $rose(rem_mode == SADIO_REM_ZERO) |=> status_out.zero_cal)
      else $error("zero cal output missing");
   AST_REM_SPAN: assert property (
      $rose(rem_mode == SADIO_REM_SPAN) |=> status_out.span_cal)
      else $error("span cal output missing");
   AST_DEB_EARLY: assert property ($rose(rem_mode == SADIO_REM_ZERO)
      |-> $past(rem_zero_in, 4) && $past(rem_zero_in, 7))
      else $error("remote mode before debounce");
   AST_DEB_LATE: assert property (
      (DEB_CYC <= 4 && rem_span_in) [*8] ##1 rem_span_in [*4]
      |-> rem_mode != SADIO_REM_NONE)
      else $error("remote mode too late");
   AST_LIMIT_WR: assert property (
      $rose(status_out.first_limit_flag) ||
      $rose(status_out.second_limit_flag) |-> $past(wr_acc, 2))
      else $error("limit flag rose without write");
   AST_STAT_WR: assert property (
      $rose(status_out.measurement_good_flag) ||
      $rose(status_out.high_range) ||
      $rose(status_out.diagnostic_active_flag) |-> $past(wr_acc, 2))
      else $error("status rose without write");
endmodule

// ==== tb/sadio_top_tb_top.sv ====
// self-checking bench for the status, alarm and remote control block
`timescale 1ns/10ps
`include "sadio_cfg.svh"
module sadio_top_tb_top;
   import sadio_pkg::*;
   localparam int unsigned DEB_CYC = 4;
   logic           core_clk;
   logic           rst;
   sadio_apb_req_s apb_req;
   logic [31:0]    prdata;
   logic           pready;
   logic           pslverr;
   logic           rem_zero_in;
   logic           rem_span_in;
   logic [3:0]     spare_in;
   sadio_status_s  status_out;
   sadio_rem_e     rem_mode;
   logic           irq;
   int             mismatches;
   int             tests_run;
   logic [31:0]    rdat;
   logic           rerr;

   // clock
   initial core_clk = 1'b0;
   always #2.5 core_clk = ~core_clk;

   sadio_top #(.DEB_CYC(DEB_CYC)) sadio_top_i (.core_clk(core_clk),
      .rst(rst), .apb_req(apb_req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rem_zero_in(rem_zero_in),
      .rem_span_in(rem_span_in), .spare_in(spare_in),
      .status_out(status_out), .rem_mode(rem_mode), .irq(irq));
   sadio_plc_model sadio_plc_model_i (.core_clk(core_clk),
      .rem_zero_in(rem_zero_in), .rem_span_in(rem_span_in),
      .spare_in(spare_in));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic results;
      begin
         $display("checks %0d mismatches %0d", tests_run, mismatches);
         if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
         end else begin
            $display("RESULT: FAIL");
         end
         $finish;
      end
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         tests_run++;
         if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   // apb transfer: setup, then access until pready
   task automatic xfer(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge core_clk);
         apb_req <= '{1'b1, 1'b0, w, a, d};
         @(posedge core_clk);
         apb_req.penable <= 1'b1;
         do begin
            @(posedge core_clk);
            n++;
         end while (pready !== 1'b1 && n < 50);
         rdat = prdata;
         rerr = pslverr;
         apb_req.psel    <= 1'b0;
         apb_req.penable <= 1'b0;
         if (pready !== 1'b1) begin
            mismatches++;
            $display("unexpected at %0t: no pready", $time);
            results();
         end
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      begin
         xfer(a, 1'b0, 32'h0);
         chk(rdat, e);
      end
   endtask
   task automatic settle;
      begin
         repeat (2) @(posedge core_clk);
         #1;
      end
   endtask
   task automatic schk(input logic [7:0] e);
      begin
         settle();
         chk({24'h0, status_out}, {24'h0, e});
      end
   endtask
   task automatic wait_mode(input sadio_rem_e m);
      int n;
      begin
         n = 0;
         while (rem_mode !== m && n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
         end
         chk({30'h0, rem_mode}, {30'h0, m});
         if (n >= 40) results();
      end
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      int i;
      mismatches = 0;
      tests_run  = 0;
      rst        = 1'b1;
      apb_req    = '0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rchk(`SADIO_OFS_LIMIT1, 32'h0000_0064);
      rchk(`SADIO_OFS_LIMIT2, 32'h0000_012C);
      rchk(`SADIO_OFS_CTRL, 32'h0000_0000);
      rchk(`SADIO_OFS_UNIT_SCALE, 32'h0000_0002);
      schk(8'h01);
      rchk(`SADIO_OFS_IRQ_STAT, 32'h0000_0001);
      wr(`SADIO_OFS_IRQ_STAT, 32'h0000_0001);
      rchk(`SADIO_OFS_IRQ_STAT, 32'h0000_0000);
      done("reset");
      wr(`SADIO_OFS_CONC, 32'h0000_0065);
      schk(8'h01);
      wr(`SADIO_OFS_CTRL, 32'h0000_0003);
      schk(8'h41);
      wr(`SADIO_OFS_CONC, 32'h0000_0064);
      schk(8'h01);
      wr(`SADIO_OFS_CONC, 32'h0000_012D);
      schk(8'hC1);
      wr(`SADIO_OFS_CTRL, 32'h0000_0001);
      schk(8'h41);
      wr(`SADIO_OFS_CONC, 32'h0000_012C);
      wr(`SADIO_OFS_CTRL, 32'h0000_0007);
      rchk(`SADIO_OFS_LIMIT1, 32'h0000_00C8);
      rchk(`SADIO_OFS_LIMIT2, 32'h0000_0258);
      schk(8'h41);
      wr(`SADIO_OFS_CTRL, 32'h0000_0003);
      rchk(`SADIO_OFS_LIMIT1, 32'h0000_0064);
      rchk(`SADIO_OFS_LIMIT2, 32'h0000_012C);
      wr(`SADIO_OFS_CONC, 32'h0000_0000);
      done("alarms");
      wr(`SADIO_OFS_CTRL, 32'h0000_0010);
      for (i = 0; i < 6; i++) begin
         wr(`SADIO_OFS_INST, 32'h0000_0001 << i);
         schk((i == 0) ? 8'h00 : (8'h01 | (8'h01 << i)));
      end
      wr(`SADIO_OFS_CTRL, 32'h0000_0000);
      wr(`SADIO_OFS_INST, 32'h0000_0004);
      schk(8'h01);
      wr(`SADIO_OFS_CTRL, 32'h0000_0020);
      schk(8'h05);
      done("status");
      wr(`SADIO_OFS_INST, 32'h0000_0000);
      wr(`SADIO_OFS_IRQ_STAT, 32'h0000_00FF);
      rchk(`SADIO_OFS_IRQ_STAT, 32'h0000_0000);
      wr(`SADIO_OFS_IRQ_MASK, 32'h0000_0002);
      wr(`SADIO_OFS_INST, 32'h0000_0002);
      settle();
      chk({31'h0, irq}, 32'h0000_0001);
      rchk(`SADIO_OFS_IRQ_STAT, 32'h0000_0002);
      wr(`SADIO_OFS_IRQ_STAT, 32'h0000_0002);
      settle();
      chk({31'h0, irq}, 32'h0000_0000);
      wr(`SADIO_OFS_IRQ_MASK, 32'h0000_0000);
      wr(`SADIO_OFS_INST, 32'h0000_0000);
      wr(`SADIO_OFS_INST, 32'h0000_0002);
      settle();
      chk({31'h0, irq}, 32'h0000_0000);
      rchk(`SADIO_OFS_IRQ_STAT, 32'h0000_0002);
      wr(`SADIO_OFS_INST, 32'h0000_0000);
      done("interrupt");
      sadio_plc_model_i.drive(1'b0, 1'b0, 4'hF, 12);
      schk(8'h01);
      wait_mode(SADIO_REM_NONE);
      sadio_plc_model_i.drive(1'b1, 1'b0, 4'h0, 2);
      sadio_plc_model_i.drive(1'b0, 1'b0, 4'h0, 12);
      wait_mode(SADIO_REM_NONE);
      // a passed glitch would have left the zero-cal event bit set
      rchk(`SADIO_OFS_IRQ_STAT, 32'h0000_0002);
      sadio_plc_model_i.drive(1'b1, 1'b0, 4'h0, 1);
      wait_mode(SADIO_REM_ZERO);
      schk(8'h09);
      rchk(`SADIO_OFS_STATUS_OUT, 32'h0000_0109);
      sadio_plc_model_i.drive(1'b0, 1'b0, 4'h0, 1);
      wait_mode(SADIO_REM_NONE);
      sadio_plc_model_i.drive(1'b0, 1'b1, 4'h0, 1);
      wait_mode(SADIO_REM_SPAN);
      schk(8'h11);
      rchk(`SADIO_OFS_STATUS_OUT, 32'h0000_0211);
      sadio_plc_model_i.drive(1'b0, 1'b0, 4'h0, 1);
      wait_mode(SADIO_REM_NONE);
      done("remote");
      xfer(12'h100, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0000);
      chk({31'h0, rerr}, 32'h0000_0001);
      wr(12'h100, 32'hFFFF_FFFF);
      rchk(`SADIO_OFS_LIMIT1, 32'h0000_0064);
      done("unmapped");
      results();
   end
endmodule

bind sadio_top sadio_top_asserts #(.DEB_CYC(DEB_CYC)) sadio_top_asserts_i (
   .core_clk(core_clk), .rst(rst), .apb_req(apb_req), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rem_zero_in(rem_zero_in),
   .rem_span_in(rem_span_in), .spare_in(spare_in),
   .status_out(status_out), .rem_mode(rem_mode), .irq(irq));
